// ===== dv/test_feature_test_control_reg.sv
`timescale 1ns/10ps
module test_feature_test_control_reg;
  import tfc_pkg::*;
  // ****************************************
  // Signals and case table
  // ****************************************
  logic ref_clk, rst_b, clk_en, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic stop_set, gie, tx_on, tp_mode, ovl;
  logic [2:0] ev;
  logic [1:0] pr;
  logic unlock, twe, burst_dis, timer_en, pad_en, strip_en, poll_go, summ, irq;
  int bad_count;
  int checked;
  int cycles;
  // Flag bit per event: missed, collision, start
  localparam logic [15:0] FLG [3] = '{16'h0200, 16'h0020, 16'h0008};
  localparam logic [15:0] ROW_W [8] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0115, 16'h00C0, 16'hFFFF};
  localparam logic [15:0] ROW_R [8] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0115, 16'h0000, 16'h7D15};
  localparam logic [3:0] ROW_O [8] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h1, 4'h0, 4'h0, 4'hF};

  tfc_ctrl #(.ADDR_W(TFC_ADDR_W)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_set(stop_set), .global_irq_enable(gie), .transmitter_on_status(tx_on), .tp_mode_pin(tp_mode),
    .missed_tally_wrap(ev[0]), .rx_coll_count_wrap(ev[1]), .tx_frame_begin(ev[2]), .overlength_pin(ovl),
    .poll_timer_tick(pr[0]), .manual_poll_req(pr[1]),
    .test_mode_unlock(unlock), .test_reg_write_en(twe), .burst_counter_disable(burst_dis),
    .bus_timer_enable(timer_en), .tx_auto_pad_enable(pad_en), .rx_auto_strip_enable(strip_en),
    .tx_poll_go(poll_go), .irq_summary_flag(summ), .irq_req(irq)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Ends one cycle after the flag lands, so the summary has caught up
  task automatic pulse_ev(input logic [2:0] e);
    @(posedge ref_clk) ev <= e;
    @(posedge ref_clk) ev <= 3'h0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic poll(input logic [1:0] p, input logic exp);
    @(posedge ref_clk) pr <= p;
    @(posedge ref_clk) pr <= 2'h0;
    #1;
    chk({15'h0, poll_go}, {15'h0, exp});
  endtask

  task automatic do_reset();
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask

  task final_report();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      final_report();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b, reg_wr, reg_rd, stop_set, gie, tx_on, tp_mode, ovl} = 8'h00;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    ev = 3'h0;
    pr = 2'h0;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    do_reset();
    rd(TFC_OFS_CTRL, TFC_CTRL_RST);
    chk({10'h0, unlock, twe, burst_dis, timer_en, pad_en, strip_en}, 16'h0000);
    rd(TFC_OFS_STAT, 16'h0002);
    @(posedge ref_clk);
    #1;
    chk(reg_rdata, 16'h0000);
    // First write without the unlock bit closes the window until reset
    wr(TFC_OFS_CTRL, 16'h0115);
    wr(TFC_OFS_CTRL, 16'h8115);
    chk({14'h0, unlock, twe}, 16'h0000);
    rd(TFC_OFS_STAT, 16'h0000);
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(TFC_OFS_CTRL, 16'h4000);
    clk_en <= 1'b1;
    rd(TFC_OFS_CTRL, 16'h0115);
    $display("test reset_unlock done");
    for (int i = 0; i < 8; i++) begin
      wr(TFC_OFS_CTRL, ROW_W[i]);
      chk({12'h000, burst_dis, timer_en, pad_en, strip_en}, {12'h000, ROW_O[i]});
      rd(TFC_OFS_CTRL, ROW_R[i]);
    end
    $display("test table done");
    wr(TFC_OFS_CTRL, 16'h0000);
    gie <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      pulse_ev(3'b001 << k);
      chk({14'h0, summ, irq}, 16'h0003);
      rd(TFC_OFS_CTRL, FLG[k]);
      wr(TFC_OFS_CTRL, FLG[k] >> 1);
      @(posedge ref_clk);
      #1;
      chk({15'h0, summ}, 16'h0000);
      wr(TFC_OFS_CTRL, 16'h0000);
      rd(TFC_OFS_CTRL, FLG[k]);
      wr(TFC_OFS_CTRL, FLG[k]);
      rd(TFC_OFS_CTRL, 16'h0000);
    end
    gie <= 1'b0;
    pulse_ev(3'h4);
    chk({14'h0, summ, irq}, 16'h0002);
    // Stop wipes flags but must leave the masks alone
    pulse_ev(3'h7);
    wr(TFC_OFS_CTRL, TFC_CTRL_RST);
    rd(TFC_OFS_CTRL, 16'h033D);
    @(posedge ref_clk) stop_set <= 1'b1;
    @(posedge ref_clk) stop_set <= 1'b0;
    rd(TFC_OFS_CTRL, TFC_CTRL_RST);
    // Event and clear in one cycle: the event must survive
    wr(TFC_OFS_CTRL, 16'h0000);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= TFC_OFS_CTRL;
    reg_wdata <= 16'h0008;
    ev <= 3'h4;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    ev <= 3'h0;
    rd(TFC_OFS_CTRL, 16'h0008);
    wr(TFC_OFS_CTRL, 16'h0008);
    $display("test events done");
    gie <= 1'b1;
    ovl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(TFC_OFS_CTRL, 16'h0000);
    ovl <= 1'b0;
    tp_mode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ovl <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({14'h0, summ, irq}, 16'h0003);
    wr(TFC_OFS_CTRL, 16'h0001);
    @(posedge ref_clk);
    #1;
    chk({14'h0, summ, irq}, 16'h0000);
    wr(TFC_OFS_CTRL, 16'h0003);
    repeat (8) @(posedge ref_clk);
    rd(TFC_OFS_CTRL, 16'h0001);
    ovl <= 1'b0;
    $display("test overlength done");
    poll(2'h1, 1'b0);
    poll(2'h2, 1'b0);
    tx_on <= 1'b1;
    poll(2'h1, 1'b1);
    wr(TFC_OFS_CTRL, 16'h1000);
    poll(2'h1, 1'b0);
    poll(2'h2, 1'b1);
    $display("test polling done");
    wr(TFC_OFS_STAT, 16'hFFFF);
    wr(4'h5, 16'hFFFF);
    rd(TFC_OFS_CTRL, 16'h1000);
    rd(4'h5, 16'h0000);
    wr(TFC_OFS_CTRL, 16'h0400);
    do_reset();
    #1;
    chk({15'h0, strip_en}, 16'h0000);
    wr(TFC_OFS_CTRL, 16'h8115);
    chk({14'h0, unlock, twe}, 16'h0003);
    wr(TFC_OFS_CTRL, 16'h0115);
    wr(TFC_OFS_CTRL, 16'h8115);
    chk({14'h0, unlock, twe}, 16'h0000);
    $display("test relock done");
    final_report();
  end
endmodule

// ===== verilog/tfc_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - Unlock bit sets only by writing one in the first write after reset.
// - Once unlock is written zero it stays clear until reset; reset clears it.
// - Unlock enables test register writes and test functions; else blocked.
// - Burst-counter disable bit turns off the burst counter; reset clears it.
// - Timer-enable bit enables the bus timer; reset clears it.
// - Poll-disable bit stops automatic transmit descriptor polling.
// - No descriptor polling of any kind while transmitter is off.
// - Hardware reset clears the receive strip enable.
// - Missed-frame tally wrap sets the missed overflow flag.
// - Missed flag clears on write one, reset or stop; zero ignored.
// - Missed mask blocks the flag from summary; reset sets, stop keeps.
// - Collision count overflow sets its flag; write one, reset, stop clear.
// - Collision mask blocks the flag from summary; reset sets, stop keeps.
// - Transmit start of each frame sets the start flag.
// - Start flag drives irq when global enable set and start mask clear.
// - Start flag clears on write one, reset or stop; zero ignored.
// - Start mask blocks the flag from summary; reset sets, stop keeps.
// - Overlength flag set by transceiver limit, only in twisted-pair mode.
// - Overlength flag drives irq when global enable set and mask clear.
// - Overlength flag clears on write one even if condition persists.
// - Overlength mask blocks the flag from summary; reset sets, stop keeps.
// - Pad enable pads short transmit frames to 64 bytes with FCS.
// - Strip enable removes pad and FCS from received frames.
// - Reset clears poll disable, so automatic polling runs after reset.
module tfc_ctrl
  import tfc_pkg::*;
#(
  parameter int ADDR_W = tfc_pkg::TFC_ADDR_W
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Device context
  input wire logic stop_set,
  input wire logic global_irq_enable,
  input wire logic transmitter_on_status,
  input wire logic tp_mode_pin,
  // Events
  input wire logic missed_tally_wrap,
  input wire logic rx_coll_count_wrap,
  input wire logic tx_frame_begin,
  input wire logic overlength_pin,
  // Polling requests from the buffer manager
  input wire logic poll_timer_tick,
  input wire logic manual_poll_req,
  // Feature controls
  output logic test_mode_unlock,
  output logic test_reg_write_en,
  output logic burst_counter_disable,
  output logic bus_timer_enable,
  output logic tx_auto_pad_enable,
  output logic rx_auto_strip_enable,
  output logic tx_poll_go,
  // Interrupt
  output logic irq_summary_flag,
  output logic irq_req
);
  import tfc_pkg::*;

  // Offsets 0 and 1 must stay distinct after the cast in hit()
  if (ADDR_W < 1) begin
    $error("ADDR_W must be at least 1");
  end

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  logic wr_ctrl;
  logic [15:0] wd;
  assign wr_ctrl = clk_en && reg_wr && hit(reg_addr, TFC_OFS_CTRL);
  assign wd = reg_wdata;

  logic tp_mode;
  logic overlength_lvl;
  tfc_sync u_sync_mode (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin_in(tp_mode_pin),
    .level_out(tp_mode)
  );
  tfc_sync u_sync_ovl (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin_in(overlength_pin),
    .level_out(overlength_lvl)
  );

  // ****************************************
  // Write-once unlock
  // ****************************************
  logic unlock_ff;
  logic first_wr_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      unlock_ff <= 1'b0;
      first_wr_ff <= 1'b1;
    end else if (wr_ctrl) begin
      first_wr_ff <= 1'b0;
      if (!wd[TFC_B_UNLOCK]) begin
        unlock_ff <= 1'b0;
      end else if (first_wr_ff) begin
        unlock_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Plain control bits
  // ****************************************
  logic burst_dis_ff;
  logic timer_en_ff;
  logic poll_dis_ff;
  logic pad_en_ff;
  logic strip_en_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      burst_dis_ff <= 1'b0;
      timer_en_ff <= 1'b0;
      poll_dis_ff <= 1'b0;
      pad_en_ff <= 1'b0;
      strip_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
      burst_dis_ff <= wd[TFC_B_BURST_DIS];
      timer_en_ff <= wd[TFC_B_TIMER_EN];
      poll_dis_ff <= wd[TFC_B_POLL_DIS];
      pad_en_ff <= wd[TFC_B_PAD_EN];
      strip_en_ff <= wd[TFC_B_STRIP_EN];
    end
  end

  // ****************************************
  // Masks: set by reset, untouched by stop
  // ****************************************
  logic [3:0] mask_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mask_ff <= 4'hF;
    end else if (wr_ctrl) begin
      mask_ff <= {wd[TFC_B_MISS_MASK], wd[TFC_B_COLL_MASK], wd[TFC_B_TXS_MASK], wd[TFC_B_OVL_MASK]};
    end
  end

  // ****************************************
  // Event flags, order: missed, collision, start, overlength
  // ****************************************
  logic ovl_dly_ff;
  logic [3:0] flag_ff;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ovl_dly_ff <= 1'b0;
    end else if (clk_en) begin
      ovl_dly_ff <= overlength_lvl;
    end
  end
  // Overlength is edge-triggered so a clear sticks while the condition lasts
  assign ev_set = {missed_tally_wrap,
                   rx_coll_count_wrap,
                   tx_frame_begin,
                   overlength_lvl && !ovl_dly_ff && tp_mode};
  assign ev_clr = wr_ctrl ? {wd[TFC_B_MISS_FLAG], wd[TFC_B_COLL_FLAG], wd[TFC_B_TXS_FLAG], wd[TFC_B_OVL_FLAG]}
                          : 4'h0;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flag_ff <= 4'h0;
    end else if (clk_en) begin
      if (stop_set) begin
        flag_ff <= ev_set;
      end else begin
        flag_ff <= (flag_ff & ~ev_clr) | ev_set;
      end
    end
  end

  // ****************************************
  // Summary and interrupt
  // ****************************************
  logic sum_now;
  logic sum_ff;
  logic irq_ff;
  assign sum_now = |(flag_ff & ~mask_ff);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sum_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      sum_ff <= sum_now;
      irq_ff <= sum_now && global_irq_enable;
    end
  end

  // ****************************************
  // Descriptor polling gate
  // ****************************************
  logic poll_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      poll_ff <= 1'b0;
    end else if (clk_en) begin
      poll_ff <= transmitter_on_status &&
                 ((poll_timer_tick && !poll_dis_ff) || manual_poll_req);
    end
  end

  // ****************************************
  // Read port, data valid the cycle after the strobe
  // ****************************************
  logic [15:0] ctrl_word;
  logic [15:0] rdata_ff;
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[TFC_B_UNLOCK] = unlock_ff;
    ctrl_word[TFC_B_BURST_DIS] = burst_dis_ff;
    ctrl_word[TFC_B_TIMER_EN] = timer_en_ff;
    ctrl_word[TFC_B_POLL_DIS] = poll_dis_ff;
    ctrl_word[TFC_B_PAD_EN] = pad_en_ff;
    ctrl_word[TFC_B_STRIP_EN] = strip_en_ff;
    ctrl_word[TFC_B_MISS_FLAG] = flag_ff[3];
    ctrl_word[TFC_B_MISS_MASK] = mask_ff[3];
    ctrl_word[TFC_B_COLL_FLAG] = flag_ff[2];
    ctrl_word[TFC_B_COLL_MASK] = mask_ff[2];
    ctrl_word[TFC_B_TXS_FLAG] = flag_ff[1];
    ctrl_word[TFC_B_TXS_MASK] = mask_ff[1];
    ctrl_word[TFC_B_OVL_FLAG] = flag_ff[0];
    ctrl_word[TFC_B_OVL_MASK] = mask_ff[0];
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_ff <= 16'h0000;
    end else if (clk_en) begin
      if (reg_rd && hit(reg_addr, TFC_OFS_CTRL)) begin
        rdata_ff <= ctrl_word & TFC_CTRL_RMASK;
      end else if (reg_rd && hit(reg_addr, TFC_OFS_STAT)) begin
        rdata_ff <= {14'h0000, first_wr_ff, sum_ff};
      end else begin
        rdata_ff <= 16'h0000;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign test_mode_unlock = unlock_ff;
  assign test_reg_write_en = unlock_ff;
  assign burst_counter_disable = burst_dis_ff;
  assign bus_timer_enable = timer_en_ff;
  assign tx_auto_pad_enable = pad_en_ff;
  assign rx_auto_strip_enable = strip_en_ff;
  assign tx_poll_go = poll_ff;
  assign irq_summary_flag = sum_ff;
  assign irq_req = irq_ff;

  // ****************************************
  // Checks
  // ****************************************
  AST_UNLOCK_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(unlock_ff) |-> $past(first_wr_ff) && $past(wr_ctrl))
    else $error("unlock set outside first write");
  AST_UNLOCK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !unlock_ff && !first_wr_ff |=> !unlock_ff)
    else $error("unlock set again after lock");
  AST_TEST_EN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(test_reg_write_en) |-> $past(first_wr_ff) && $past(wr_ctrl) && $past(wd[TFC_B_UNLOCK]))
    else $error("test write enable opened outside first write");
  AST_BURST: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_ctrl |=> burst_counter_disable == $past(wd[TFC_B_BURST_DIS]))
    else $error("burst disable not stored");
  AST_TIMER: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_ctrl |=> bus_timer_enable == $past(wd[TFC_B_TIMER_EN]))
    else $error("timer enable not stored");
  AST_POLL_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !transmitter_on_status |=> !tx_poll_go)
    else $error("poll while transmitter off");
  AST_POLL_DIS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && poll_dis_ff && !manual_poll_req |=> !tx_poll_go)
    else $error("auto poll while disabled");
  AST_EVENT_WINS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && tx_frame_begin |=> flag_ff[1])
    else $error("start event lost");
  AST_MISS_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && missed_tally_wrap |=> flag_ff[3] ##1 (flag_ff[3] || $past(ev_clr[3]) || $past(stop_set)))
    else $error("missed flag not sticky");
  AST_STOP_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && stop_set && !tx_frame_begin |=> !flag_ff[1])
    else $error("stop did not clear start flag");
  AST_MASK_STOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stop_set && !wr_ctrl |=> $stable(mask_ff))
    else $error("stop changed masks");
  AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && flag_ff[0] && !mask_ff[0] && global_irq_enable |=> irq_req)
    else $error("overlength irq missing");
  AST_SUMMARY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> irq_summary_flag == |($past(flag_ff) & ~$past(mask_ff)))
    else $error("summary mismatch");
  AST_MISS_W1C: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && ev_clr[3] && !missed_tally_wrap |=> !flag_ff[3])
    else $error("missed flag not cleared by write one");
  AST_STOP_ALL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && stop_set && ev_set == 4'h0 |=> flag_ff == 4'h0)
    else $error("stop left a flag set");
  AST_COLL_W1C: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && ev_clr[2] && !rx_coll_count_wrap |=> !flag_ff[2])
    else $error("collision flag not cleared by write one");
  AST_MASK_GATE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && (flag_ff & ~mask_ff) == 4'h0 |=> !irq_summary_flag)
    else $error("masked flag reached summary");
  AST_START_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && flag_ff[1] && !mask_ff[1] && global_irq_enable |=> irq_req)
    else $error("start irq missing");
  AST_START_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && flag_ff[1] && !ev_clr[1] && !stop_set |=> flag_ff[1])
    else $error("start flag lost without clear");
  AST_OVL_MODE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(flag_ff[0]) |-> $past(tp_mode))
    else $error("overlength flag set outside twisted-pair mode");
  AST_OVL_W1C: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && ev_clr[0] && !ev_set[0] |=> !flag_ff[0])
    else $error("overlength flag not cleared by write one");
  AST_PAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_ctrl |=> tx_auto_pad_enable == $past(wd[TFC_B_PAD_EN]))
    else $error("pad enable not stored");
  AST_STRIP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_ctrl |=> rx_auto_strip_enable == $past(wd[TFC_B_STRIP_EN]))
    else $error("strip enable not stored");
  AST_POLL_AUTO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && transmitter_on_status && poll_timer_tick && !poll_dis_ff |=> tx_poll_go)
    else $error("auto poll request dropped");
endmodule

// ===== verilog/tfc_pkg.sv
package tfc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int TFC_ADDR_W = 4;
  localparam int TFC_DATA_W = 16;
  localparam logic [3:0] TFC_OFS_CTRL = 4'h0;
  localparam logic [3:0] TFC_OFS_STAT = 4'h1;
  // ****************************************
  // Field positions in the control word
  // ****************************************
  localparam int TFC_B_UNLOCK = 15;
  localparam int TFC_B_BURST_DIS = 14;
  localparam int TFC_B_TIMER_EN = 13;
  localparam int TFC_B_POLL_DIS = 12;
  localparam int TFC_B_PAD_EN = 11;
  localparam int TFC_B_STRIP_EN = 10;
  localparam int TFC_B_MISS_FLAG = 9;
  localparam int TFC_B_MISS_MASK = 8;
  localparam int TFC_B_COLL_FLAG = 5;
  localparam int TFC_B_COLL_MASK = 4;
  localparam int TFC_B_TXS_FLAG = 3;
  localparam int TFC_B_TXS_MASK = 2;
  localparam int TFC_B_OVL_FLAG = 1;
  localparam int TFC_B_OVL_MASK = 0;
  // Status word: bit 0 summary, bit 1 unlock window still open
  localparam int TFC_B_ST_SUM = 0;
  localparam int TFC_B_ST_WIN = 1;
  localparam logic [15:0] TFC_CTRL_RST = 16'h0115;
  localparam logic [15:0] TFC_CTRL_RMASK = 16'hFF3F;
  localparam int TFC_SYNC_STAGES = 3;
endpackage

// ===== verilog/tfc_sync.sv
`timescale 1ns/10ps
// Pin synchroniser: three stages, change accepted when stages two and three agree
module tfc_sync (
  // Clocking
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Data
  input wire logic pin_in,
  output logic level_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else if (clk_en) begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_out = level_ff;
endmodule
